// ---- tb_tts_tape_transport_op_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_tts_tape_transport_op_sequencer;
  typedef struct packed {logic [15:0] v; logic [15:0] m;} tts_exp_type;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rd_prev = 1'b0;
  logic [7:0] addr = 8'h00, rd_base = 8'h00, c;
  logic [15:0] wdata = 16'h0000, rdata, a0;
  logic irq, forward_cmd, rewind_cmd, write_enable, slave_set_pulse, stop;
  logic acceleration_indication, write_parity, record_strobe, bad_par = 1'b0, skew = 1'b0;
  logic [2:0] slave_select, density_select_lines;
  logic [7:0] write_data;
  logic write_timing_clock, read_strobe, slave_ready, vert_parity_error;
  logic [8:0] read_data_lines;
  logic [31:0] seed = 32'h5, r;
  logic [7:0] wch [0:2];
  tts_exp_type rq[$], e;
  logic [7:0] cq[$];
  int num_errors = 0, check_count = 0, pulses = 0;

  always #12.5 clk = ~clk;

  tts_tape_transport_op_sequencer i_dut (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
    .slave_select(slave_select), .forward_cmd(forward_cmd), .rewind_cmd(rewind_cmd),
    .write_enable(write_enable), .slave_set_pulse(slave_set_pulse), .stop(stop),
    .acceleration_indication(acceleration_indication),
    .density_select_lines(density_select_lines), .write_data(write_data),
    .write_parity(write_parity), .record_strobe(record_strobe),
    .write_timing_clock(write_timing_clock), .read_strobe(read_strobe),
    .slave_ready(slave_ready), .vert_parity_error(vert_parity_error),
    .read_data_lines(read_data_lines));

  tts_transport_model i_model (.slave_set_pulse(slave_set_pulse), .forward_cmd(forward_cmd),
    .write_enable(write_enable), .stop(stop), .acceleration_indication(acceleration_indication),
    .rd_base(rd_base), .bad_par(bad_par), .skew(skew),
    .write_timing_clock(write_timing_clock), .read_strobe(read_strobe),
    .slave_ready(slave_ready), .read_data_lines(read_data_lines),
    .vert_parity_error(vert_parity_error));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==================================================================
  // Host port
  task automatic wr_reg(logic [7:0] a, logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(logic [7:0] a, logic [15:0] v, logic [15:0] m);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    rq.push_back('{v, m});
    @(posedge clk);
    rd <= 1'b0;
  endtask

  task automatic wait_for(ref logic s);
    for (int n = 0; n < 4000 && s !== 1'b1; n++) @(negedge clk);
  endtask

  task automatic clr();
    wr_reg(tts_pkg::REG_STATUS, 16'h0007);
    @(negedge clk);
    check("irq cleared", {15'h0, irq}, 16'h0000);
  endtask

  // ==================================================================
  // Output watcher: each result takes the oldest note
  always @(posedge clk) begin
    if (rd_prev) begin
      e = rq.pop_front();
      check("rdata", rdata & e.m, e.v & e.m);
    end
    rd_prev = rd;
    if (record_strobe) begin
      c = (cq.size() > 0) ? cq.pop_front() : ~write_data;
      check("write_data", {8'h00, write_data}, {8'h00, c});
      check("write_parity", {15'h0, write_parity}, {15'h0, ~^c});
      check("accel in data", {15'h0, acceleration_indication}, 16'h0000);
    end
    if (slave_set_pulse) begin
      pulses++;
      check("stop at set", {15'h0, stop}, 16'h0000);
    end
  end

  // Go, watch the launch, refill data per character, wait for done
  task automatic run_op(logic [1:0] fn, logic [2:0] sel, logic pe, logic [15:0] cnt);
    wr_reg(tts_pkg::REG_COUNT, cnt);
    wr_reg(tts_pkg::REG_CMD, {9'h000, 1'b1, pe, sel, fn});
    wait_for(slave_set_pulse);
    check("select", {13'h0, slave_select}, {13'h0, sel});
    check("density", {13'h0, density_select_lines},
          {13'h0, pe ? tts_pkg::DEN_1600 : tts_pkg::DEN_800});
    check("forward", {15'h0, forward_cmd}, {15'h0, fn != tts_pkg::FN_REWIND});
    check("write_enable", {15'h0, write_enable}, {15'h0, fn == tts_pkg::FN_WRITE});
    check("accel at start", {15'h0, acceleration_indication}, 16'h0001);
    for (int k = 1; k < 3 && fn == tts_pkg::FN_WRITE && !skew; k++) begin
      wait_for(record_strobe);
      wr_reg(tts_pkg::REG_DATA, {8'h00, wch[k]});
    end
    wait_for(irq);
    check("done irq", {15'h0, irq}, 16'h0001);
    check("stop at end", {15'h0, stop}, 16'h0001);
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    print_verdict();
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(tts_pkg::REG_ACCDLY, {tts_pkg::ACCDLY_RST}, 16'hFFFF);
    rd_reg(tts_pkg::REG_POSTDLY, {tts_pkg::POSTDLY_RST}, 16'hFFFF);
    rd_reg(8'h24, 16'h0000, 16'hFFFF);
    r = xs();
    a0 = r[15:0];
    wr_reg(tts_pkg::REG_ADDR, a0);
    rd_reg(tts_pkg::REG_ADDR, a0, 16'hFFFF);
    wr_reg(tts_pkg::REG_CMD, 16'h0035);
    rd_reg(tts_pkg::REG_CMD, 16'h0035, 16'h007F);
    wr_reg(tts_pkg::REG_ACCDLY, 16'h0001);
    wr_reg(tts_pkg::REG_POSTDLY, 16'h0001);
    wr_reg(tts_pkg::REG_MASK, 16'h0001);
    $display("test registers done");
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 3; k++) begin
        r = xs();
        wch[k] = r[7:0];
        cq.push_back(wch[k]);
      end
      cq.push_back(p ? 8'h00 : wch[0] ^ wch[1] ^ wch[2]);
      wr_reg(tts_pkg::REG_DATA, {8'h00, wch[0]});
      run_op(tts_pkg::FN_WRITE, 3'(p + 5), p[0], 16'h0003);
      rd_reg(tts_pkg::REG_STATUS, 16'h0803, 16'h0F07);
      rd_reg(tts_pkg::REG_ADDR, a0 + 16'(3 * (p + 1)), 16'hFFFF);
      clr();
      $display("test write %0d done", p);
    end
    for (int f = 1; f < 4; f++) begin
      r = xs();
      rd_base <= r[7:0];
      bad_par <= (f == 3);
      run_op(f[1:0] & 2'h1 | 2'(f == 2) << 1, r[10:8], 1'b0, 16'h0002);
      rd_reg(tts_pkg::REG_STATUS, {4'h0, 1'b1, f == 3, 7'h00, f == 3, 2'h1}, 16'h0F05);
      rd_reg(tts_pkg::REG_DATA, {8'h00, r[7:0] + 8'h01}, {8'h00, {8{f != 2}}});
      clr();
      $display("test read %0d done", f);
    end
    bad_par <= 1'b0;
    skew <= 1'b1;
    run_op(tts_pkg::FN_WRITE, 3'h2, 1'b0, 16'h0003);
    skew <= 1'b0;
    rd_reg(tts_pkg::REG_STATUS, 16'h0A05, 16'h0F07);
    clr();
    $display("test abort done");
    wr_reg(tts_pkg::REG_MASK, 16'h0000);
    wr_reg(tts_pkg::REG_CMD, {9'h000, 1'b1, 1'b0, 3'h4, tts_pkg::FN_REWIND});
    repeat (60) @(negedge clk);
    check("rewind cmd", {15'h0, rewind_cmd}, 16'h0001);
    check("irq masked", {15'h0, irq}, 16'h0000);
    wr_reg(tts_pkg::REG_MASK, 16'h0001);
    @(negedge clk);
    check("irq unmasked", {15'h0, irq}, 16'h0001);
    clr();
    check("set pulses", 16'(pulses), 16'h0007);
    $display("test rewind done");
    print_verdict();
  end
endmodule
`default_nettype wire

// ---- tts_pkg.sv ----
// ====================================================================
// Constants shared by the tape operation sequencer
package tts_pkg;

  // ==================================================================
  // Host register map, byte addresses
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_COUNT  = 8'h04;
  localparam logic [7:0] REG_ADDR   = 8'h08;
  localparam logic [7:0] REG_DATA   = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_MASK   = 8'h14;
  localparam logic [7:0] REG_ACCDLY = 8'h18;
  localparam logic [7:0] REG_POSTDLY = 8'h1C;

  // ==================================================================
  // Command register fields
  localparam int CMD_FN_LO  = 0;
  localparam int CMD_SEL_LO = 2;
  localparam int CMD_PE     = 5;
  localparam int CMD_GO     = 6;
  localparam logic [1:0] FN_WRITE  = 2'h0;
  localparam logic [1:0] FN_READ   = 2'h1;
  localparam logic [1:0] FN_SPACE  = 2'h2;
  localparam logic [1:0] FN_REWIND = 2'h3;

  // Density select codes
  localparam logic [2:0] DEN_800  = 3'h2;
  localparam logic [2:0] DEN_1600 = 3'h4;

  // ==================================================================
  // Status bits: low three sticky, busy and ready live, hard and soft held until the next go
  localparam int ST_DONE  = 0;
  localparam int ST_CHAR  = 1;
  localparam int ST_ERR   = 2;
  localparam int ST_BUSY  = 8;
  localparam int ST_HARD  = 9;
  localparam int ST_SOFT  = 10;
  localparam int ST_READY = 11;

  // ==================================================================
  // Reset values and timing
  localparam logic [15:0] ACCDLY_RST  = 16'h0010;
  localparam logic [15:0] POSTDLY_RST = 16'h0008;
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_NS       = 1000;
  localparam logic [5:0] TICK_CYCLES = 6'(TICK_NS / CLK_PERIOD_NS);

  // Synchroniser vector layout
  localparam int SY_WCLK = 0;
  localparam int SY_RSTB = 1;
  localparam int SY_RDY  = 2;
  localparam int SY_VPE  = 3;
  localparam int SY_RD   = 4;
  localparam int SY_W    = 13;

  typedef enum logic [6:0] {
    S_IDLE  = 7'h01,
    S_START = 7'h02,
    S_ACCEL = 7'h04,
    S_XFER  = 7'h08,
    S_EOR   = 7'h10,
    S_POST  = 7'h20,
    S_HALT  = 7'h40
  } tts_state_type;

endpackage

// ---- tts_tape_transport_op_sequencer.sv ----
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R1: Host loads command, count and address registers by address decode and strobe.
// R2: Command selects the transport and decodes into transport command lines.
// R3: Set pulse only after the selected transport reports ready.
// R4: Transport moves tape forward on read, write or space forward.
// R5: Count acceleration delay, then drop acceleration indication before any data.
// R6: Transport paces each written character with write timing clock pulses.
// R7: Write enable is asserted to open the write channels during writes.
// R8: One record strobe per character, each with its own parity bit.
// R9: Count characters; at the count write end character or postamble.
// R10: Read logic stays on during writes and checks readback parity.
// R11: Skew errors abort at once; parity errors are reported at the end.
// R12: On read, read data lines load the data buffer register.
// R13: After end, count post delay, then assert stop.
// R14: Host reads any register back through a select multiplexer.
// R15: Stop is released before the set pulse; rewind ends on its own.
// R16: Acceleration indication high while idle or accelerating, low during data.
// R17: Write timing clock comes only at speed; rate follows density select. The transport model toggles it every 100 ns at either density.
// R18: Density select: 800 bpi is 010, 1600 bpi is 100.
// R19: One set pulse per operation, none until the previous one has stopped.
module tts_tape_transport_op_sequencer (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Host register port
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  output logic             irq,
  // Transport commands
  output logic      [2:0]  slave_select,
  output logic             forward_cmd,
  output logic             rewind_cmd,
  output logic             write_enable,
  output logic             slave_set_pulse,
  output logic             stop,
  output logic             acceleration_indication,
  output logic      [2:0]  density_select_lines,
  // Write channel
  output logic      [7:0]  write_data,
  output logic             write_parity,
  output logic             record_strobe,
  // Transport status and read channel
  input  wire logic        write_timing_clock,
  input  wire logic        read_strobe,
  input  wire logic        slave_ready,
  input  wire logic        vert_parity_error,
  input  wire logic [8:0]  read_data_lines
);

  // ==================================================================
  // Decode used by both the write and the read side
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  tts_pkg::tts_state_type st_q;
  logic [6:0]  cmd_q;
  logic [15:0] count_q, addr_q, cnt_q, acc_q, post_q, dly_q;
  logic [8:0]  dat_q;
  logic [2:0]  stat_q, mask_q;
  logic [7:0]  lrc_q;
  logic [5:0]  div_q;
  logic        hard_q, soft_q, tick;
  logic [tts_pkg::SY_W-1:0] sy1_q, sy2_q;
  logic [1:0]  edge_q;

  // ==================================================================
  // Input synchronisers; the first stage feeds only the second
  // Data and strobe share one depth, so a strobe edge meets settled data
  wire logic [tts_pkg::SY_W-1:0] raw = {read_data_lines, vert_parity_error, slave_ready,
                                        read_strobe, write_timing_clock};
  for (genvar i = 0; i < tts_pkg::SY_W; i++) begin : g_sync
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        sy1_q[i] <= 1'b0;
        sy2_q[i] <= 1'b0;
      end else begin
        sy1_q[i] <= raw[i];
        sy2_q[i] <= sy1_q[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) edge_q <= 2'h0;
    else edge_q <= {sy2_q[tts_pkg::SY_RSTB], sy2_q[tts_pkg::SY_WCLK]};
  end

  wire logic       rdy_s   = sy2_q[tts_pkg::SY_RDY];
  wire logic       vpe_s   = sy2_q[tts_pkg::SY_VPE];
  wire logic [8:0] rd_s    = sy2_q[tts_pkg::SY_RD +: 9];
  wire logic       wclk_up = sy2_q[tts_pkg::SY_WCLK] & ~edge_q[0];
  wire logic       rs_up   = sy2_q[tts_pkg::SY_RSTB] & ~edge_q[1];

  // ==================================================================
  // Decoded events
  wire logic [1:0] fn      = cmd_q[tts_pkg::CMD_FN_LO +: 2];
  wire logic       is_wr   = (fn == tts_pkg::FN_WRITE);
  wire logic       go      = wr & hit(addr, tts_pkg::REG_CMD) & wdata[tts_pkg::CMD_GO]
                             & (st_q == tts_pkg::S_IDLE);
  wire logic       ch_wr   = (st_q == tts_pkg::S_XFER) & is_wr & wclk_up & ~vpe_s;
  wire logic       ch_rd   = (st_q == tts_pkg::S_XFER) & ~is_wr & rs_up & ~vpe_s;
  wire logic       rb_chk  = (st_q == tts_pkg::S_XFER) & is_wr & rs_up;
  wire logic       eor_go  = (st_q == tts_pkg::S_EOR) & wclk_up;
  wire logic       last    = (16'(cnt_q + 16'h0001) >= count_q);
  wire logic       done_ev = (st_q == tts_pkg::S_HALT) & rdy_s;
  wire logic       rewound = (st_q == tts_pkg::S_START) & rdy_s & ~stop & (fn == tts_pkg::FN_REWIND);
  wire logic       rd_par_bad = ~(^rd_s);
  wire logic [2:0] ev      = {(done_ev | rewound) & (hard_q | soft_q), ch_wr | ch_rd,
                              done_ev | rewound};

  // ==================================================================
  // Microsecond tick for the motion delays
  localparam logic [5:0] TICK_M1 = tts_pkg::TICK_CYCLES - 6'h01;
  // Free-running tick keeps delays cheap; each delay may run up to one tick longer
  assign tick = (div_q == TICK_M1);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) div_q <= 6'h00;
    else if (tick) div_q <= 6'h00;
    else div_q <= div_q + 6'h01;
  end

  // ==================================================================
  // Operation sequence
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q            <= tts_pkg::S_IDLE;
      slave_set_pulse <= 1'b0;
      stop            <= 1'b1;
      dly_q           <= 16'h0000;
    end else begin
      slave_set_pulse <= 1'b0;
      if (tick && dly_q != 16'h0000) dly_q <= dly_q - 16'h0001;
      case (st_q)
        tts_pkg::S_IDLE: begin
          if (go) begin
            st_q <= tts_pkg::S_START;
            stop <= 1'b0;                                                   // R15
          end
        end
        tts_pkg::S_START: begin
          if (rdy_s && !stop) begin                                         // R3
            slave_set_pulse <= 1'b1;                                        // R19
            dly_q <= acc_q;                                                 // R5
            st_q  <= (fn == tts_pkg::FN_REWIND) ? tts_pkg::S_IDLE : tts_pkg::S_ACCEL;  // R15
          end
        end
        tts_pkg::S_ACCEL: begin
          if (tick && dly_q == 16'h0000) st_q <= tts_pkg::S_XFER;           // R5
        end
        tts_pkg::S_XFER: begin
          // Count 0 behaves as 1: the first character already reaches the end
          if (vpe_s) begin
            st_q  <= tts_pkg::S_POST;                                       // R11
            dly_q <= post_q;
          end else if ((ch_wr || ch_rd) && last) begin
            st_q  <= is_wr ? tts_pkg::S_EOR : tts_pkg::S_POST;              // R9
            dly_q <= post_q;                                                // R13
          end
        end
        tts_pkg::S_EOR: begin
          if (wclk_up) begin
            st_q  <= tts_pkg::S_POST;
            dly_q <= post_q;
          end
        end
        tts_pkg::S_POST: begin
          if (tick && dly_q == 16'h0000) begin
            stop <= 1'b1;                                                   // R13
            st_q <= tts_pkg::S_HALT;
          end
        end
        tts_pkg::S_HALT: begin
          if (rdy_s) st_q <= tts_pkg::S_IDLE;                               // R19
        end
        default: st_q <= tts_pkg::S_IDLE;
      endcase
    end
  end

  // Acceleration indication drops only while characters move; it stays low while
  // the end character's strobe stands, which leaves the data state one cycle early
  assign acceleration_indication = ~((st_q == tts_pkg::S_XFER) | (st_q == tts_pkg::S_EOR)
                                     | record_strobe); // R16

  // ==================================================================
  // Transport command lines, latched when an operation is launched
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slave_select         <= 3'h0;
      forward_cmd          <= 1'b0;
      rewind_cmd           <= 1'b0;
      write_enable         <= 1'b0;
      density_select_lines <= tts_pkg::DEN_800;
    end else if (go) begin
      slave_select <= wdata[tts_pkg::CMD_SEL_LO +: 3];                      // R2
      forward_cmd  <= (wdata[1:0] != tts_pkg::FN_REWIND);
      rewind_cmd   <= (wdata[1:0] == tts_pkg::FN_REWIND);
      write_enable <= (wdata[1:0] == tts_pkg::FN_WRITE);                    // R7
      density_select_lines <= wdata[tts_pkg::CMD_PE] ? tts_pkg::DEN_1600 : tts_pkg::DEN_800; // R18
    end
  end

  // ==================================================================
  // Write channel; end character is the running check character at 800 bpi, all zeros at 1600 bpi
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      write_data    <= 8'h00;
      write_parity  <= 1'b1;
      record_strobe <= 1'b0;
      lrc_q         <= 8'h00;
    end else begin
      record_strobe <= ch_wr | eor_go;                                      // R8
      if (go) lrc_q <= 8'h00;
      if (ch_wr) begin
        write_data   <= dat_q[7:0];
        write_parity <= ~(^dat_q[7:0]);                                     // R8
        lrc_q        <= lrc_q ^ dat_q[7:0];
      end else if (eor_go) begin
        write_data   <= cmd_q[tts_pkg::CMD_PE] ? 8'h00 : lrc_q;             // R9
        write_parity <= cmd_q[tts_pkg::CMD_PE] ? 1'b1 : ~(^lrc_q);
      end
    end
  end

  // ==================================================================
  // Host registers, counters and error flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_q   <= 7'h00;
      count_q <= 16'h0000;
      addr_q  <= 16'h0000;
      dat_q   <= 9'h000;
      mask_q  <= 3'h0;
      acc_q   <= tts_pkg::ACCDLY_RST;
      post_q  <= tts_pkg::POSTDLY_RST;
      cnt_q   <= 16'h0000;
      hard_q  <= 1'b0;
      soft_q  <= 1'b0;
    end else begin
      // Command, count, address and delay writes are refused while busy so a running operation cannot be retargeted
      if (wr && st_q == tts_pkg::S_IDLE) begin                              // R1
        if (hit(addr, tts_pkg::REG_CMD)) cmd_q <= {1'b0, wdata[5:0]};
        if (hit(addr, tts_pkg::REG_COUNT)) count_q <= wdata;
        if (hit(addr, tts_pkg::REG_ADDR)) addr_q <= wdata;
        if (hit(addr, tts_pkg::REG_ACCDLY)) acc_q <= wdata;
        if (hit(addr, tts_pkg::REG_POSTDLY)) post_q <= wdata;
      end
      if (wr && hit(addr, tts_pkg::REG_MASK)) mask_q <= wdata[2:0];
      if (ch_rd && fn == tts_pkg::FN_READ) dat_q <= rd_s;                   // R12
      else if (wr && hit(addr, tts_pkg::REG_DATA)) dat_q <= wdata[8:0];
      if (go) begin
        cnt_q  <= 16'h0000;
        hard_q <= 1'b0;
        soft_q <= 1'b0;
      end else if (ch_wr || ch_rd) begin
        cnt_q  <= cnt_q + 16'h0001;                                         // R9
        addr_q <= addr_q + 16'h0001;
      end
      if (st_q == tts_pkg::S_XFER && vpe_s) hard_q <= 1'b1;                 // R11
      if ((ch_rd || rb_chk) && rd_par_bad) soft_q <= 1'b1;                  // R10
    end
  end

  // ==================================================================
  // Sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) stat_q <= 3'h0;
    else if (wr && hit(addr, tts_pkg::REG_STATUS)) stat_q <= (stat_q & ~wdata[2:0]) | ev;
    else stat_q <= stat_q | ev;
  end
  assign irq = |(stat_q & mask_q);

  // ==================================================================
  // Read-back multiplexer, data one cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rdata <= 16'h0000;
    else if (rd) begin
      rdata <= 16'h0000;                                                    // R14
      if (hit(addr, tts_pkg::REG_CMD)) rdata <= {9'h000, cmd_q};
      if (hit(addr, tts_pkg::REG_COUNT)) rdata <= count_q;
      if (hit(addr, tts_pkg::REG_ADDR)) rdata <= addr_q;
      if (hit(addr, tts_pkg::REG_DATA)) rdata <= {7'h00, dat_q};
      if (hit(addr, tts_pkg::REG_STATUS))
        rdata <= {4'h0, rdy_s, soft_q, hard_q, st_q != tts_pkg::S_IDLE, 5'h00, stat_q};
      if (hit(addr, tts_pkg::REG_MASK)) rdata <= {13'h0000, mask_q};
      if (hit(addr, tts_pkg::REG_ACCDLY)) rdata <= acc_q;
      if (hit(addr, tts_pkg::REG_POSTDLY)) rdata <= post_q;
    end
  end

  // ==================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_set_when_ready: assert property (slave_set_pulse |-> $past(rdy_s) && !stop) // R3
    else $error("set pulse without ready transport");
  a_stop_released: assert property ($rose(slave_set_pulse) |-> $past(!stop)) // R15
    else $error("stop still asserted before set pulse");
  a_single_start: assert property (slave_set_pulse |=> !slave_set_pulse [*8]) // R19
    else $error("second set pulse too soon");
  a_acceleration_indication_data_low: assert property (record_strobe |-> !acceleration_indication // R16
    && $past(!acceleration_indication))
    else $error("character written while accelerating");
  a_wen_on_rec: assert property (record_strobe |-> write_enable) // R7
    else $error("record strobe without write enable");
  a_rec_parity: assert property (record_strobe |-> (^{write_data, write_parity})) // R8
    else $error("bad parity on written character");
  a_rec_paced: assert property (record_strobe |-> $past(wclk_up)) // R8
    else $error("record strobe not paced by write clock");
  a_skew_abort: assert property ((st_q == tts_pkg::S_XFER) && vpe_s |=> st_q == tts_pkg::S_POST) // R11
    else $error("skew error did not abort");
  a_read_load: assert property (ch_rd && fn == tts_pkg::FN_READ |=> dat_q == $past(rd_s)) // R12
    else $error("read character not loaded");
  a_stop_post: assert property ($rose(stop) |-> $past(st_q == tts_pkg::S_POST) && $past(tick)) // R13
    else $error("stop without post delay");
  a_rd_status: assert property (rd && hit(addr, tts_pkg::REG_STATUS) |=> rdata[2:0] == $past(stat_q)) // R14
    else $error("status read back wrong");
  a_eor_follows: assert property (eor_go |=> record_strobe ##1 !record_strobe) // R9
    else $error("end character not written");

  // ==================================================================
  // Latched command lines against the command register while busy
  wire logic in_motion = (st_q == tts_pkg::S_ACCEL) | (st_q == tts_pkg::S_XFER)
                         | (st_q == tts_pkg::S_EOR) | (st_q == tts_pkg::S_POST);

  a_cmd_lines: assert property (slave_set_pulse |-> forward_cmd != rewind_cmd) // R2
    else $error("forward and rewind lines agree at set pulse");
  a_wen_match: assert property ((st_q != tts_pkg::S_IDLE) |-> write_enable == is_wr) // R7
    else $error("write enable does not match the function");
  a_den_match: assert property ((st_q != tts_pkg::S_IDLE) |-> density_select_lines == // R18
    (cmd_q[tts_pkg::CMD_PE] ? tts_pkg::DEN_1600 : tts_pkg::DEN_800))
    else $error("density lines do not match the mode");
  a_stop_moving: assert property (in_motion |-> !stop) // R13
    else $error("stop asserted while tape moves");
  a_rewind_idle: assert property (slave_set_pulse && rewind_cmd |-> st_q == tts_pkg::S_IDLE) // R15
    else $error("rewind did not end on its own");

endmodule
`default_nettype wire

// ---- tts_transport_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ====================================================================
// Transport stand-in: moves on the set pulse, paces characters
module tts_transport_model (
  // Commands from the sequencer
  input  wire logic       slave_set_pulse,
  input  wire logic       forward_cmd,
  input  wire logic       write_enable,
  input  wire logic       stop,
  input  wire logic       acceleration_indication,
  // Test controls
  input  wire logic [7:0] rd_base,
  input  wire logic       bad_par,
  input  wire logic       skew,
  // Status and read channel
  output logic            write_timing_clock,
  output logic            read_strobe,
  output logic            slave_ready,
  output logic [8:0]      read_data_lines,
  output logic            vert_parity_error
);
  logic       moving = 1'b0;
  logic [7:0] k      = 8'h00;
  assign slave_ready       = ~moving;
  assign vert_parity_error = skew & moving;
  initial begin
    write_timing_clock = 1'b0;
    read_strobe = 1'b0;
    read_data_lines = 9'h000;
  end
  // ==================================================================
  // Motion
  always @(posedge slave_set_pulse) begin
    moving = forward_cmd;
    k = 8'h00;
  end
  // Ready comes back only after deceleration
  always @(posedge stop) begin
    #150 moving = 1'b0;
  end
  // ==================================================================
  // Character pacing; the write clock stands still when not at speed
  always begin
    #100;
    if (moving && write_enable && !acceleration_indication) begin
      write_timing_clock = ~write_timing_clock;
    end else begin
      write_timing_clock = 1'b0;
    end
  end
  // Lines are inverted between strobes so stale data never looks valid
  always begin
    #200;
    if (moving && !write_enable && !acceleration_indication && !read_strobe) begin
      read_data_lines = {~^(rd_base + k) ^ bad_par, rd_base + k};
      read_strobe = 1'b1;
      k = k + 8'h01;
    end else begin
      read_data_lines = ~read_data_lines;
      read_strobe = 1'b0;
    end
  end
endmodule
`default_nettype wire
